// File: rtl/adcs_sequencer.sv
// Summary of operation
// RULE1 - Reset converter, stable clock before any writes
// RULE2 - Link enable zero halts link engine
// RULE3 - Calibration run zero halts calibration next
// RULE4 - Write multiframe length as count minus one
// RULE5 - Multiframe count within ceiling and floor bounds
// RULE6 - SYSREF rate ties to lane rate
// RULE7 - Single-channel device clock is half rate
// RULE8 - Handshake source picks pin or timestamp input
// RULE9 - Choose background or foreground, offset calibration
// RULE10 - Calibration run one restarts calibration engine
// RULE11 - Set overrange enable after calibration restart
// RULE12 - Continuous SYSREF before link restart
// RULE13 - Confirm SYSREF capture before link restart
// RULE14 - Link enable one restarts link afterwards
// RULE15 - Device link follows receiver handshake
// RULE16 - Trigger written zero then one starts calibration
// RULE17 - Low rails enabled after high rail good
// RULE18 - Low rails drop when high rail fails
// RULE19 - SYSREF active whenever receiver requests sync (here on from the capture step until high rail loss, whatever the sync request)
// RULE20 - Writes strictly ordered, each completed first
`include "adcs_defines.svh"

module adcs_sequencer #(
    parameter int unsigned SYSREF_TMO_CYCLES = `ADCS_SYSREF_TMO_CYCLES
) (
    input  wire logic                   SYS_CLK_I,
    input  wire logic                   RESET_N_I,
    adcs_if.ctrl                        cfg,
    input  wire logic                   START_I,
    input  wire logic                   CLK_STABLE_I,
    input  wire logic                   HIGH_RAIL_GOOD_I,
    input  wire logic [7:0]             LINK_FORMAT_I,
    input  wire logic [5:0]             FRAMES_PER_MF_I,
    input  wire logic [7:0]             FRAMES_PER_LANE_I,
    input  wire logic                   HS_SEL_I,
    input  wire logic                   CAL_BACKGROUND_I,
    input  wire logic                   OFFSET_CAL_I,
    input  wire logic                   OVERRANGE_EN_I,
    output logic                        LOW_RAIL_EN_O,
    output logic                        SYSREF_EN_O,
    output logic                        BUSY_O,
    output logic                        DONE_O,
    output logic                        CONFIG_ERROR_O,
    output logic                        SYSREF_FAIL_O
);
    import adcs_pkg::*;

    localparam logic [23:0] TMO = 24'(SYSREF_TMO_CYCLES);

    adcs_ctrl_state_t r;
    adcs_ctrl_state_t next_r;
    logic             rail_good;
    logic             k_ok;
    logic [13:0]      kf;
    logic [15:0]      step_wr;

    // Address and data of each step, in issue order
    function automatic logic [15:0] step_write(input logic [3:0] step);
        logic [7:0] mf_m1;
        mf_m1 = 8'({2'b00, FRAMES_PER_MF_I} - 8'h01);
        unique case (step)
            // RULE2 link halt
            4'd0:  step_write = {`ADCS_ADDR_LINK_EN, 8'h00};
            // RULE3 calibration halt
            4'd1:  step_write = {`ADCS_ADDR_CAL_RUN, 8'h00};
            4'd2:  step_write = {`ADCS_ADDR_LINK_FMT, LINK_FORMAT_I};
            // RULE4 length minus one
            4'd3:  step_write = {`ADCS_ADDR_MF_LEN_M1, mf_m1};
            // RULE8 handshake select
            4'd4:  step_write = {`ADCS_ADDR_HS_SEL, 7'h00, HS_SEL_I};
            // RULE9 calibration mode
            4'd5:  step_write = {`ADCS_ADDR_CAL_CFG, 6'h00, OFFSET_CAL_I, CAL_BACKGROUND_I};
            // RULE10 calibration rerun
            4'd6:  step_write = {`ADCS_ADDR_CAL_RUN, 8'h01};
            // RULE11 overrange enable
            4'd7:  step_write = {`ADCS_ADDR_OVERRANGE, 7'h00, OVERRANGE_EN_I};
            // RULE13 SYSREF capture check
            4'd8:  step_write = {`ADCS_ADDR_SYSREF_CAL, 8'h01};
            // RULE14 link restart
            4'd9:  step_write = {`ADCS_ADDR_LINK_EN, 8'h01};
            // RULE16 trigger low then high
            4'd10: step_write = {`ADCS_ADDR_CAL_TRIG, 8'h00};
            default: step_write = {`ADCS_ADDR_CAL_TRIG, 8'h01};
        endcase
    endfunction : step_write

    always_comb begin
        next_r = r;
        next_r.good_sync = {r.good_sync[0], HIGH_RAIL_GOOD_I};
        rail_good = r.good_sync[1];
        // RULE5 multiframe bounds
        kf = 14'(FRAMES_PER_MF_I) * 14'(FRAMES_PER_LANE_I);
        k_ok = (kf >= `ADCS_K_MIN_PRODUCT) && (kf <= `ADCS_K_MAX_PRODUCT)
               && (FRAMES_PER_MF_I <= `ADCS_K_MAX) && (FRAMES_PER_MF_I != 6'h00);
        step_wr = step_write(r.step);
        next_r.busy = 1'b1;
        // RULE18 rail loss shutdown
        // Checked in every state: IDLE after a failed run still holds the rails up
        if (!rail_good) begin
            next_r.seq = SEQ_IDLE;
            next_r.busy = 1'b0;
            next_r.low_rail_en = 1'b0;
            next_r.sysref_en = 1'b0;
            next_r.wr_valid = 1'b0;
            next_r.done = 1'b0;
        end else begin
            unique case (r.seq)
                SEQ_IDLE: begin
                    next_r.busy = 1'b0;
                    // RULE17 low rails after good
                    if (rail_good && START_I) begin
                        next_r.low_rail_en = 1'b1;
                        next_r.seq = SEQ_POWER;
                        next_r.done = 1'b0;
                        next_r.cfg_error = 1'b0;
                        next_r.sysref_fail = 1'b0;
                    end
                end
                SEQ_POWER: next_r.seq = SEQ_WAIT_CLK;
                SEQ_WAIT_CLK: begin
                    // RULE1 clock before writes
                    if (CLK_STABLE_I) begin
                        if (!k_ok) begin
                            next_r.cfg_error = 1'b1;
                            next_r.seq = SEQ_FAIL;
                        end else begin
                            next_r.step = 4'd0;
                            next_r.seq = SEQ_WRITE;
                        end
                    end
                end
                SEQ_WRITE: begin
                    // RULE12 SYSREF on first
                    // RULE19 SYSREF before sync
                    if (r.step >= `ADCS_STEP_SYSREF_CAL) begin
                        next_r.sysref_en = 1'b1;
                    end
                    // RULE20 one write at a time
                    if (!r.wr_valid) begin
                        next_r.wr_valid = 1'b1;
                        next_r.wr_addr = step_wr[15:8];
                        next_r.wr_data = step_wr[7:0];
                    end else if (cfg.wr_ready) begin
                        next_r.wr_valid = 1'b0;
                        next_r.step = r.step + 4'd1;
                        if (r.step == `ADCS_STEP_SYSREF_CAL) begin
                            next_r.tmo_cnt = TMO;
                            next_r.seq = SEQ_SYSREF_WAIT;
                        end else if (r.step == `ADCS_STEP_LAST) begin
                            next_r.seq = SEQ_DONE;
                        end
                    end
                end
                SEQ_SYSREF_WAIT: begin
                    // RULE13 wait capture result
                    if (cfg.sysref_cal_done) begin
                        next_r.seq = SEQ_WRITE;
                    end else if (r.tmo_cnt == 24'h000000) begin
                        next_r.sysref_fail = 1'b1;
                        next_r.seq = SEQ_FAIL;
                    end else begin
                        next_r.tmo_cnt = r.tmo_cnt - 24'h000001;
                    end
                end
                SEQ_DONE: begin
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                    if (START_I) begin
                        next_r.seq = SEQ_IDLE;
                    end
                end
                SEQ_FAIL: begin
                    // Rails stay up so software can retry without a power cycle
                    next_r.busy = 1'b0;
                    if (!START_I) begin
                        next_r.seq = SEQ_IDLE;
                    end
                end
                default: next_r.seq = SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            r <= '{seq: SEQ_IDLE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign cfg.wr_valid    = r.wr_valid;
    assign cfg.wr_addr     = r.wr_addr;
    assign cfg.wr_data     = r.wr_data;
    assign LOW_RAIL_EN_O   = r.low_rail_en;
    assign SYSREF_EN_O     = r.sysref_en;
    assign BUSY_O          = r.busy;
    assign DONE_O          = r.done;
    assign CONFIG_ERROR_O  = r.cfg_error;
    assign SYSREF_FAIL_O   = r.sysref_fail;

endmodule : adcs_sequencer

// File: rtl/adcs_defines.svh
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

// Configuration write addresses
`define ADCS_ADDR_LINK_EN      8'h00
`define ADCS_ADDR_CAL_RUN      8'h01
`define ADCS_ADDR_LINK_FMT     8'h02
`define ADCS_ADDR_MF_LEN_M1    8'h03
`define ADCS_ADDR_HS_SEL       8'h04
`define ADCS_ADDR_CAL_CFG      8'h05
`define ADCS_ADDR_OVERRANGE    8'h06
`define ADCS_ADDR_SYSREF_CAL   8'h07
`define ADCS_ADDR_CAL_TRIG     8'h08

// Field positions
`define ADCS_CAL_CFG_BG_BIT    0
`define ADCS_CAL_CFG_OFS_BIT   1

// Reset values
`define ADCS_RST_LINK_FMT      8'h00
`define ADCS_RST_MF_LEN_M1     5'h1f
`define ADCS_RST_HS_SEL        1'b0

// Multiframe length limits
`define ADCS_K_MIN_PRODUCT     14'd17
`define ADCS_K_MAX             6'd32
`define ADCS_K_MAX_PRODUCT     14'd1024

// Sequence step numbers
`define ADCS_STEP_SYSREF_CAL   4'd8
`define ADCS_STEP_LAST         4'd11

// Timing
`define ADCS_CLK_PERIOD_NS     100
`define ADCS_CAL_TIME_NS       100000
`define ADCS_CAL_CYCLES        (`ADCS_CAL_TIME_NS / `ADCS_CLK_PERIOD_NS)
`define ADCS_SYSREF_TMO_NS     2000000
`define ADCS_SYSREF_TMO_CYCLES (`ADCS_SYSREF_TMO_NS / `ADCS_CLK_PERIOD_NS)
`define ADCS_ILAS_MF_COUNT     4

`endif

// File: rtl/adcs_pkg.sv
package adcs_pkg;

    typedef enum logic [1:0] {
        LINK_OFF,
        LINK_CGS,
        LINK_ILAS,
        LINK_DATA
    } adcs_link_state_t;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_POWER,
        SEQ_WAIT_CLK,
        SEQ_WRITE,
        SEQ_SYSREF_WAIT,
        SEQ_DONE,
        SEQ_FAIL
    } adcs_seq_state_t;

    typedef struct packed {
        logic             link_enable;
        logic             cal_run;
        logic [7:0]       link_format_select;
        logic [4:0]       multiframe_length_minus_one;
        logic             hs_sel;
        logic             cal_background;
        logic             offset_cal;
        logic             overrange_enable;
        logic             calibration_software_trigger;
        logic             wr_ready;
        adcs_link_state_t link;
        logic [6:0]       ilas_cnt;
        logic             cal_busy;
        logic             cal_done;
        logic [15:0]      cal_cnt;
        logic             sr_pend;
        logic             sr_done;
        logic [1:0]       se_sync;
        logic [1:0]       ts_sync;
        logic [1:0]       sr_sync;
        logic             sr_prev;
    } adcs_dev_state_t;

    typedef struct packed {
        adcs_seq_state_t  seq;
        logic [3:0]       step;
        logic             wr_valid;
        logic [7:0]       wr_addr;
        logic [7:0]       wr_data;
        logic             low_rail_en;
        logic             sysref_en;
        logic [23:0]      tmo_cnt;
        logic             busy;
        logic             done;
        logic             cfg_error;
        logic             sysref_fail;
        logic [1:0]       good_sync;
    } adcs_ctrl_state_t;

endpackage : adcs_pkg

// File: rtl/adcs_if.sv
interface adcs_if;
    logic       wr_valid;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       wr_ready;
    logic       sysref_cal_done;

    modport ctrl (
        output wr_valid,
        output wr_addr,
        output wr_data,
        input  wr_ready,
        input  sysref_cal_done
    );

    modport dev (
        input  wr_valid,
        input  wr_addr,
        input  wr_data,
        output wr_ready,
        output sysref_cal_done
    );
endinterface : adcs_if

// File: rtl/adcs_device.sv
`include "adcs_defines.svh"

module adcs_device (
    input  wire logic                   SYS_CLK_I,
    input  wire logic                   RESET_N_I,
    adcs_if.dev                         cfg,
    input  wire logic                   SYNC_SE_N_I,
    input  wire logic                   SYNC_TS_N_I,
    input  wire logic                   SYSREF_I,
    output logic [1:0]                  LINK_STATE_O,
    output logic [7:0]                  LINK_FORMAT_O,
    output logic [4:0]                  MF_LEN_M1_O,
    output logic                        CAL_BACKGROUND_O,
    output logic                        OFFSET_CAL_O,
    output logic                        OVERRANGE_EN_O,
    output logic                        CAL_BUSY_O,
    output logic                        CAL_DONE_O
);
    import adcs_pkg::*;

    localparam logic [15:0] CAL_CYCLES = 16'(`ADCS_CAL_CYCLES);

    adcs_dev_state_t r;
    adcs_dev_state_t next_r;
    logic            take;
    logic            sync_req;
    logic            trig_rise;
    logic            sr_rise;

    always_comb begin
        next_r = r;
        take = cfg.wr_valid & r.wr_ready;
        trig_rise = 1'b0;
        // Synchronisers for pins
        next_r.se_sync = {r.se_sync[0], SYNC_SE_N_I};
        next_r.ts_sync = {r.ts_sync[0], SYNC_TS_N_I};
        next_r.sr_sync = {r.sr_sync[0], SYSREF_I};
        next_r.sr_prev = r.sr_sync[1];
        sr_rise = r.sr_sync[1] & ~r.sr_prev;
        // RULE8 handshake source select
        sync_req = r.hs_sel ? ~r.ts_sync[1] : ~r.se_sync[1];
        // One write per two cycles; ready drops for the cycle after a take
        next_r.wr_ready = ~take;
        if (take) begin
            unique case (cfg.wr_addr)
                `ADCS_ADDR_LINK_EN: begin
                    // RULE2 link halt
                    // RULE14 link restart
                    next_r.link_enable = cfg.wr_data[0];
                end
                `ADCS_ADDR_CAL_RUN: begin
                    // RULE3 calibration halt
                    // RULE10 calibration rerun
                    next_r.cal_run = cfg.wr_data[0];
                end
                `ADCS_ADDR_LINK_FMT: next_r.link_format_select = cfg.wr_data;
                `ADCS_ADDR_MF_LEN_M1: next_r.multiframe_length_minus_one = cfg.wr_data[4:0];
                `ADCS_ADDR_HS_SEL: next_r.hs_sel = cfg.wr_data[0];
                `ADCS_ADDR_CAL_CFG: begin
                    next_r.cal_background = cfg.wr_data[`ADCS_CAL_CFG_BG_BIT];
                    next_r.offset_cal = cfg.wr_data[`ADCS_CAL_CFG_OFS_BIT];
                end
                `ADCS_ADDR_OVERRANGE: next_r.overrange_enable = cfg.wr_data[0];
                `ADCS_ADDR_SYSREF_CAL: begin
                    next_r.sr_pend = cfg.wr_data[0];
                    next_r.sr_done = 1'b0;
                end
                `ADCS_ADDR_CAL_TRIG: begin
                    // RULE16 trigger edge
                    next_r.calibration_software_trigger = cfg.wr_data[0];
                    trig_rise = cfg.wr_data[0] & ~r.calibration_software_trigger;
                end
                default: ;
            endcase
        end
        // SYSREF capture check waits for a real SYSREF edge
        if (r.sr_pend && sr_rise) begin
            next_r.sr_pend = 1'b0;
            next_r.sr_done = 1'b1;
        end
        // Calibration engine; halting it aborts a run in progress
        if (!r.cal_run) begin
            next_r.cal_busy = 1'b0;
        end else if (trig_rise) begin
            next_r.cal_busy = 1'b1;
            next_r.cal_done = 1'b0;
            next_r.cal_cnt = CAL_CYCLES;
        end else if (r.cal_busy) begin
            next_r.cal_cnt = r.cal_cnt - 16'h0001;
            if (r.cal_cnt == 16'h0001) begin
                next_r.cal_busy = 1'b0;
                next_r.cal_done = 1'b1;
            end
        end
        // RULE15 link follows handshake
        if (!r.link_enable) begin
            next_r.link = LINK_OFF;
        end else begin
            unique case (r.link)
                LINK_OFF: next_r.link = LINK_CGS;
                LINK_CGS: begin
                    if (!sync_req) begin
                        next_r.link = LINK_ILAS;
                        next_r.ilas_cnt = 7'({2'b00, r.multiframe_length_minus_one} + 7'h01)
                                          * 7'(`ADCS_ILAS_MF_COUNT);
                    end
                end
                LINK_ILAS: begin
                    next_r.ilas_cnt = r.ilas_cnt - 7'h01;
                    if (sync_req) begin
                        next_r.link = LINK_CGS;
                    end else if (r.ilas_cnt == 7'h01) begin
                        next_r.link = LINK_DATA;
                    end
                end
                LINK_DATA: begin
                    if (sync_req) begin
                        next_r.link = LINK_CGS;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            r <= '{link_enable: 1'b1, cal_run: 1'b1,
                   link_format_select: `ADCS_RST_LINK_FMT,
                   multiframe_length_minus_one: `ADCS_RST_MF_LEN_M1,
                   hs_sel: `ADCS_RST_HS_SEL, link: LINK_OFF,
                   se_sync: 2'h3, ts_sync: 2'h3, wr_ready: 1'b0, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign cfg.wr_ready        = r.wr_ready;
    assign cfg.sysref_cal_done = r.sr_done;
    assign LINK_STATE_O        = r.link;
    assign LINK_FORMAT_O       = r.link_format_select;
    assign MF_LEN_M1_O         = r.multiframe_length_minus_one;
    assign CAL_BACKGROUND_O    = r.cal_background;
    assign OFFSET_CAL_O        = r.offset_cal;
    assign OVERRANGE_EN_O      = r.overrange_enable;
    assign CAL_BUSY_O          = r.cal_busy;
    assign CAL_DONE_O          = r.cal_done;

endmodule : adcs_device

// File: testbench/adcs_asserts.sv
`include "adcs_defines.svh"

module adcs_asserts (
    input  wire logic       SYS_CLK_I,
    input  wire logic       RESET_N_I,
    input  wire logic       wr_valid,
    input  wire logic [7:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_ready,
    input  wire logic       sysref_cal_done
);
    timeunit 1ns;
    timeprecision 1ns;

    logic       take;
    logic [7:0] last_addr;
    logic [7:0] last_data;

    assign take = wr_valid && wr_ready;

    // Last taken write, so order can be judged at the next take
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            last_addr <= 8'hff;
            last_data <= 8'hff;
        end else if (take) begin
            last_addr <= wr_addr;
            last_data <= wr_data;
        end
    end

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    sequence s_take;
        wr_valid && wr_ready;
    endsequence
    sequence s_gap;
        !wr_ready ##1 wr_ready;
    endsequence

    property p_hold;
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data);
    endproperty
    a_hold: assert property (p_hold) else $error("request moved");
    property p_drop;
        s_take |=> !wr_valid;
    endproperty
    a_drop: assert property (p_drop) else $error("valid held");
    property p_answer;
        s_take |=> s_gap;
    endproperty
    a_answer: assert property (p_answer) else $error("ready gap");
    property p_cal_stop;
        take && wr_addr == `ADCS_ADDR_CAL_RUN && wr_data == 8'h00
            |-> last_addr == `ADCS_ADDR_LINK_EN && last_data == 8'h00;
    endproperty
    a_cal_stop: assert property (p_cal_stop) else $error("cal stop order");
    property p_km1;
        take && wr_addr == `ADCS_ADDR_MF_LEN_M1 |-> last_addr == `ADCS_ADDR_LINK_FMT;
    endproperty
    a_km1: assert property (p_km1) else $error("length order");
    property p_ovr;
        take && wr_addr == `ADCS_ADDR_OVERRANGE
            |-> last_addr == `ADCS_ADDR_CAL_RUN && last_data == 8'h01;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrange order");
    property p_link_on;
        take && wr_addr == `ADCS_ADDR_LINK_EN && wr_data == 8'h01
            |-> last_addr == `ADCS_ADDR_SYSREF_CAL && sysref_cal_done;
    endproperty
    a_link_on: assert property (p_link_on) else $error("link restart early");
    property p_trig;
        take && wr_addr == `ADCS_ADDR_CAL_TRIG && wr_data == 8'h01
            |-> last_addr == `ADCS_ADDR_CAL_TRIG && last_data == 8'h00;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger order");
endmodule : adcs_asserts

// File: testbench/adc_link_bringup_sequencer_bench.sv
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR %0t mismatch", $time); end end

module adc_link_bringup_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, rst_n, start, stable, rail, se_n, ts_n, blk;
    logic sysref = 1'b0;
    logic [7:0] fmt, fl, fmt_o;
    logic [5:0] kf;
    logic [4:0] mf_o;
    logic [3:0] cfg;
    logic [3:0] cnt_sr = 4'h0;
    logic [1:0] link_st;
    logic bg_o, ofs_o, ovr_o, busy_c, cal_d, low_en, sr_en, busy, done, err, sfail;
    int bad_count, n_checks, cycles;
    logic [5:0] kt [4] = '{6'h02, 6'h03, 6'h20, 6'h21};
    logic [7:0] ft [4] = '{8'h08, 8'h06, 8'h20, 8'h01};
    logic       et [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

    adcs_if bus ();
    adcs_sequencer #(.SYSREF_TMO_CYCLES(50)) adcs_sequencer_i (
        .SYS_CLK_I(clk), .RESET_N_I(rst_n), .cfg(bus), .START_I(start),
        .CLK_STABLE_I(stable), .HIGH_RAIL_GOOD_I(rail), .LINK_FORMAT_I(fmt),
        .FRAMES_PER_MF_I(kf), .FRAMES_PER_LANE_I(fl), .HS_SEL_I(cfg[3]),
        .CAL_BACKGROUND_I(cfg[2]), .OFFSET_CAL_I(cfg[1]), .OVERRANGE_EN_I(cfg[0]),
        .LOW_RAIL_EN_O(low_en), .SYSREF_EN_O(sr_en), .BUSY_O(busy), .DONE_O(done),
        .CONFIG_ERROR_O(err), .SYSREF_FAIL_O(sfail));
    adcs_device adcs_device_i (
        .SYS_CLK_I(clk), .RESET_N_I(rst_n), .cfg(bus), .SYNC_SE_N_I(se_n),
        .SYNC_TS_N_I(ts_n), .SYSREF_I(sysref), .LINK_STATE_O(link_st),
        .LINK_FORMAT_O(fmt_o), .MF_LEN_M1_O(mf_o), .CAL_BACKGROUND_O(bg_o),
        .OFFSET_CAL_O(ofs_o), .OVERRANGE_EN_O(ovr_o), .CAL_BUSY_O(busy_c),
        .CAL_DONE_O(cal_d));
    adcs_asserts adcs_asserts_i (
        .SYS_CLK_I(clk), .RESET_N_I(rst_n), .wr_valid(bus.wr_valid),
        .wr_addr(bus.wr_addr), .wr_data(bus.wr_data), .wr_ready(bus.wr_ready),
        .sysref_cal_done(bus.sysref_cal_done));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Continuous SYSREF while enabled; blk withholds it to force a capture failure
    // continuous SYSREF source
    always @(posedge clk) begin
        cnt_sr <= cnt_sr + 4'h1;
        sysref <= sr_en && !blk && cnt_sr[3];
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            bad_count++;
            stop_test();
        end
    end

    task stop_test;
        if (bad_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic wait_end(input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (done !== 1'b1 && err !== 1'b1 && sfail !== 1'b1 && n < lim);
        `CHK(n < lim, 1'b1)
    endtask : wait_end

    task automatic run_seq(input logic [5:0] k, input logic [7:0] f,
                           input logic [3:0] c, input logic b);
        @(posedge clk);
        start <= 1'b0;
        kf <= k;
        fl <= f;
        cfg <= c;
        fmt <= {4'h0, c};
        blk <= b;
        repeat (3) @(posedge clk);
        start <= 1'b1;
        // DONE needs one edge to reach IDLE and IDLE one more to restart
        repeat (2) @(posedge clk);
        start <= 1'b0;
        wait_end(3000);
    endtask : run_seq

    task automatic check_ok(input logic [5:0] k, input logic [3:0] c);
        `CHK({done, busy}, 2'b10)
        `CHK(mf_o, 5'(k - 6'h01))
        `CHK(fmt_o, {4'h0, c})
        `CHK({bg_o, ofs_o, ovr_o}, c[2:0])
    endtask : check_ok

    initial begin
        int n;
        {rst_n, start, stable, rail, blk, se_n, ts_n} = 7'h02;
        {fmt, kf, fl, cfg} = {8'h0d, 6'h08, 8'h08, 4'hd};
        {bad_count, n_checks} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        start <= 1'b1;
        repeat (6) @(negedge clk);
        `CHK(low_en, 1'b0)
        @(posedge clk) rail <= 1'b1;
        repeat (8) @(negedge clk);
        `CHK({low_en, bus.wr_valid, busy}, 3'b101)
        // Start is a level; dropping it keeps DONE from restarting the sequence
        @(posedge clk);
        stable <= 1'b1;
        start <= 1'b0;
        wait_end(3000);
        check_ok(6'h08, 4'hd);
        repeat (2) @(negedge clk);
        `CHK({busy_c, link_st, sr_en}, 4'b1011)
        // Timestamp input is the selected handshake; the idle pin must be ignored
        @(posedge clk) ts_n <= 1'b1;
        repeat (6) @(negedge clk);
        `CHK(link_st, 2'h2)
        repeat (40) @(negedge clk);
        `CHK(link_st, 2'h3)
        @(posedge clk) ts_n <= 1'b0;
        repeat (6) @(negedge clk);
        `CHK({link_st, sr_en}, 3'h3)
        repeat (830) @(negedge clk);
        `CHK({busy_c, cal_d}, 2'b10)
        n = 0;
        while (cal_d !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        `CHK({busy_c, cal_d}, 2'b01)
        @(posedge clk);
        rail <= 1'b0;
        start <= 1'b0;
        repeat (5) @(negedge clk);
        `CHK({low_en, sr_en}, 2'b00)
        @(posedge clk) rail <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            run_seq(kt[i], ft[i], 4'(i + 2), 1'b0);
            `CHK(err, et[i])
            if (et[i] == 1'b0) check_ok(kt[i], 4'(i + 2));
        end
        run_seq(6'h08, 8'h08, 4'h1, 1'b1);
        `CHK({sfail, done, link_st}, 4'b1000)
        // A failed run leaves the rails up in IDLE; losing the high rail must still drop them
        @(posedge clk) rail <= 1'b0;
        repeat (5) @(negedge clk);
        `CHK({low_en, busy}, 2'b00)
        stop_test();
    end
endmodule : adc_link_bringup_sequencer_bench
